/* snc_pkg.sv */
// package: register map, field positions and timing for the system/non-maskable interrupt control
package snc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TRAP_ARM = 8'h40;
  localparam logic [7:0] IDX_SRC_EN   = 8'h41;
  localparam logic [7:0] IDX_TRAPPED  = 8'h42;
  localparam logic [7:0] IDX_FLAGS    = 8'h43;
  localparam logic [7:0] IDX_IRQ_ACT  = 8'h44;
  localparam logic [7:0] IDX_PIO_BASE = 8'h45;
  localparam logic [7:0] IDX_PIO_TMR  = 8'h46;
  localparam logic [7:0] IDX_DRV_TMR  = 8'h47;
  localparam logic [7:0] IDX_REV      = 8'h64;
  localparam logic [7:0] IDX_A20      = 8'h6b;
  localparam logic [7:0] IDX_PWR_EN   = 8'h82;
  localparam logic [7:0] IDX_FORCE    = 8'h88;
  localparam logic [7:0] IDX_PSTAT    = 8'ha2;
  localparam logic [7:0] IDX_MODE     = 8'ha4;
  localparam logic [7:0] IDX_ACK      = 8'ha5;
  localparam logic [7:0] IDX_SOCKET   = 8'ha9;
  localparam logic [7:0] IDX_PAGE     = 8'haa;
  localparam logic [7:0] IDX_PCTL3    = 8'had;
  localparam logic [7:0] IDX_FEN1     = 8'hb0;
  localparam logic [7:0] IDX_PIN      = 8'hb3;
  // field positions
  localparam int B_PMU_FLAG  = 5;
  localparam int B_TICK_FLAG = 6;
  localparam int B_RTC_EN    = 3;
  localparam int B_KBD_EN    = 4;
  localparam int B_TICK_EN   = 5;
  localparam int B_SMI_SEL   = 7;
  localparam int B_REV_SMI   = 7;
  localparam int B_EXT_EN    = 4;
  localparam int B_EXT_POL   = 5;
  localparam int B_PIN_STATE = 1;
  // power source order in the ack register: mode, wake, level1, level2, level3
  localparam int S_MODE = 0;
  localparam int S_WAKE = 1;
  // fixed io decodes
  localparam logic [9:0] FDD_BASE = 10'h3f0;
  localparam logic [9:0] HDD_BASE = 10'h1f0;
  localparam logic [9:0] DRV_MASK = 10'h007;
  localparam logic [9:0] RTC_BASE = 10'h070;
  localparam logic [9:0] KBD_DATA = 10'h060;
  localparam logic [9:0] KBD_CMD  = 10'h064;
  // reset values
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] RST_ARM   = 8'h07;
  localparam logic [3:0] REV_CODE  = 4'h1;   // arbitrary revision code
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
  // idle timer unit: 1 ms at 20 MHz
  localparam int CLK_MHZ   = 20;
  localparam int T_UNIT_US = 1000;
  localparam int UNIT_CYC  = T_UNIT_US * CLK_MHZ;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HSW  = 4'b0010,
    ST_ON   = 4'b0100,
    ST_STOP = 4'b1000
  } snc_state_e;
endpackage

/* snc_ctl.sv */
// module: system/non-maskable interrupt control with temporary-on and idle-device timers
// Summary of operation
// - only mode change, battery level and wake sources may become NMI
// - routable sources run stopped clocks, slow rate outside PLL modes, until refresh
// - mode and battery sources keep prior mode; high-speed keeps its rate
// - wake source reaches high-speed mode before the interrupt is raised
// - ack write ends temporary-on; mode-change source advances to next mode
// - temporary-on holds activity, wake and timers; latched events replay on exit
// - clocks stop at first refresh after the ack write
// - socket bit 7 low sends routable sources to NMI
// - save page formed from page register and socket bits 5:4
// - address bit 20 forced low during handler when enabled
// - revision bit 7 tells whether last core reset came during handler
// - pin state and per-source flags readable, power unit flag bit 5
// - power status write resets power and tick generation
// - transition during handler stays queued until its own ack
// - three idle timers, 15 timeouts each plus off, cleared by device access
// - pio base from register, decode size from timer bits 7:6
// - drive irqs optionally count as activity, never trap
// - first access traps then starts timer; expiry arms next trap
// - expiry drives the device power bit low
// - trapped cycle lines captured at end of trapping command
// - writing 0 arms unconditional trap; no trap during handler
`timescale 1ns/1ps
`default_nettype none
module snc_ctl #(
  parameter int UNIT_CYC = snc_pkg::UNIT_CYC
) (
  // clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // pins
  input  wire logic        external_sysint_pin,
  input  wire logic        suspend_resume_pin,
  input  wire logic        battery_level_one_n,
  input  wire logic        battery_level_two_n,
  input  wire logic        battery_level_three_n,
  // power unit and core
  input  wire logic        mode_change_event,
  input  wire logic [2:0]  power_mode,
  input  wire logic        in_pll_mode,
  input  wire logic        in_high_speed,
  input  wire logic        activity_event,
  input  wire logic        wake_event,
  input  wire logic        refresh_tick,
  input  wire logic        cpu_in_sysint,
  input  wire logic        core_reset_req,
  input  wire logic        timer_tick_interrupt,
  input  wire logic        floppy_irq,
  input  wire logic        disk_irq,
  // io cycle
  input  wire logic        io_cycle_end,
  input  wire logic [9:0]  io_addr,
  input  wire logic        io_read_strobe_n,
  input  wire logic        io_write_strobe_n,
  input  wire logic        byte_high_enable_n,
  // interrupt and clock control
  output logic             sysint_req,
  output logic             nmi_req,
  output logic             clk_run,
  output logic             slow_clk_sel,
  output logic             goto_high_speed,
  output logic             hold_power_unit,
  output logic             advance_mode,
  output logic             replay_activity,
  output logic             a20_force_low,
  output logic [9:0]       save_page,
  output logic [2:0]       device_power_clear,
  output logic             force_mode_valid,
  output logic [2:0]       force_mode
);
  logic dp_q, dpw_q, map_q, rdy_q;
  logic [7:0] idx_q;
  logic [31:0] rdat_q;
  logic [7:0] rv;
  logic wr, rd;
  logic [7:0] en41_q, irqa_q, piob_q, piot_q, drvt_q, a20c_q, en82_q;
  logic [7:0] sock_q, page_q, pc3_q, fen1_q;
  logic [6:0] flags_q;
  logic [4:0] ack_q, seen_q, ev;
  logic [3:0] trapped_q;
  logic rev_smi_q;
  logic [1:0] ext_s, sr_s, b1_s, b2_s, b3_s;
  logic sr_d, b1_d, b2_d, b3_d, tick_d;
  logic ext_act, any_trap, misc_trap;
  logic [2:0] hit, iact, trap, expire, arm_w;
  logic [3:0] tsel [3];
  logic [31:0] unit_q;
  logic unit_tick;
  logic wake_pend_q, mode_src_q, act_lat_q;
  snc_pkg::snc_state_e st_q, st_d;
  logic smi_q, nmi_q, run_q, slow_q, hs_q, hold_q, adv_q, rep_q, a20_q;
  logic [9:0] pg_q;
  logic [2:0] pclr_q;
  logic fv_q;
  logic [2:0] fm_q;

  assign wr = dp_q & dpw_q & map_q;
  assign rd = dp_q & ~dpw_q & map_q;

  // one wait state on every transfer so read data comes from a flop
  always_ff @(posedge mclk) begin
    if (rst) begin
      dp_q  <= 1'b0;
      dpw_q <= 1'b0;
      map_q <= 1'b0;
      idx_q <= snc_pkg::RST_ZERO;
      rdy_q <= 1'b1;
    end else if (ce) begin
      if (hready & hsel & htrans[1]) begin
        dp_q  <= 1'b1;
        dpw_q <= hwrite;
        map_q <= (haddr[31:10] == 22'h00_0000);
        idx_q <= haddr[9:2];
        rdy_q <= 1'b0;
      end else begin
        dp_q  <= 1'b0;
        rdy_q <= 1'b1;
      end
    end
  end

  always_comb begin
    unique case (idx_q)
      snc_pkg::IDX_TRAP_ARM: rv = {5'h00, arm_w};
      snc_pkg::IDX_SRC_EN:   rv = en41_q;
      snc_pkg::IDX_TRAPPED:  rv = {4'h0, trapped_q};
      snc_pkg::IDX_FLAGS:    rv = {1'b0, flags_q};
      snc_pkg::IDX_IRQ_ACT:  rv = irqa_q;
      snc_pkg::IDX_PIO_BASE: rv = piob_q;
      snc_pkg::IDX_PIO_TMR:  rv = piot_q;
      snc_pkg::IDX_DRV_TMR:  rv = drvt_q;
      snc_pkg::IDX_REV:      rv = {rev_smi_q, 3'h0, snc_pkg::REV_CODE};
      snc_pkg::IDX_A20:      rv = a20c_q;
      snc_pkg::IDX_PWR_EN:   rv = en82_q;
      snc_pkg::IDX_FORCE:    rv = {5'h00, fm_q};
      snc_pkg::IDX_PSTAT:    rv = {6'h00, flags_q[snc_pkg::B_TICK_FLAG], flags_q[snc_pkg::B_PMU_FLAG]};
      snc_pkg::IDX_MODE:     rv = {5'h00, power_mode};
      snc_pkg::IDX_ACK:      rv = {3'h0, ack_q};
      snc_pkg::IDX_SOCKET:   rv = sock_q;
      snc_pkg::IDX_PAGE:     rv = page_q;
      snc_pkg::IDX_PCTL3:    rv = pc3_q;
      snc_pkg::IDX_FEN1:     rv = fen1_q;
      snc_pkg::IDX_PIN:      rv = {6'h00, ext_s[1], 1'b0};
      default:               rv = snc_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdat_q <= snc_pkg::RD_ZERO;
    end else if (ce && dp_q) begin
      rdat_q <= rd ? {24'h00_0000, rv} : snc_pkg::RD_ZERO;
    end
  end

  // plain control registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      en41_q <= snc_pkg::RST_ZERO;
      irqa_q <= snc_pkg::RST_ZERO;
      piob_q <= snc_pkg::RST_ZERO;
      piot_q <= snc_pkg::RST_ZERO;
      drvt_q <= snc_pkg::RST_ZERO;
      a20c_q <= snc_pkg::RST_ZERO;
      en82_q <= snc_pkg::RST_ZERO;
      sock_q <= snc_pkg::RST_ZERO;
      page_q <= snc_pkg::RST_ZERO;
      pc3_q  <= snc_pkg::RST_ZERO;
      fen1_q <= snc_pkg::RST_ZERO;
    end else if (ce && wr) begin
      unique case (idx_q)
        snc_pkg::IDX_SRC_EN:   en41_q <= hwdata[7:0];
        snc_pkg::IDX_IRQ_ACT:  irqa_q <= hwdata[7:0];
        snc_pkg::IDX_PIO_BASE: piob_q <= hwdata[7:0];
        snc_pkg::IDX_PIO_TMR:  piot_q <= hwdata[7:0];
        snc_pkg::IDX_DRV_TMR:  drvt_q <= hwdata[7:0];
        snc_pkg::IDX_A20:      a20c_q <= hwdata[7:0];
        snc_pkg::IDX_PWR_EN:   en82_q <= hwdata[7:0];
        snc_pkg::IDX_SOCKET:   sock_q <= hwdata[7:0];
        snc_pkg::IDX_PAGE:     page_q <= hwdata[7:0];
        snc_pkg::IDX_PCTL3:    pc3_q  <= hwdata[7:0];
        snc_pkg::IDX_FEN1:     fen1_q <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // forced mode request handed to the power unit as a one-cycle pulse
  always_ff @(posedge mclk) begin
    if (rst) begin
      fv_q <= 1'b0;
      fm_q <= 3'h0;
    end else if (ce) begin
      fv_q <= wr && (idx_q == snc_pkg::IDX_FORCE);
      if (wr && (idx_q == snc_pkg::IDX_FORCE))
        fm_q <= hwdata[2:0];
    end
  end

  // pin synchronisers; only the second stage is looked at
  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_s <= 2'b00;
      sr_s  <= 2'b00;
      b1_s  <= 2'b11;
      b2_s  <= 2'b11;
      b3_s  <= 2'b11;
      sr_d  <= 1'b0;
      b1_d  <= 1'b1;
      b2_d  <= 1'b1;
      b3_d  <= 1'b1;
      tick_d <= 1'b0;
    end else if (ce) begin
      ext_s <= {ext_s[0], external_sysint_pin};
      sr_s  <= {sr_s[0], suspend_resume_pin};
      b1_s  <= {b1_s[0], battery_level_one_n};
      b2_s  <= {b2_s[0], battery_level_two_n};
      b3_s  <= {b3_s[0], battery_level_three_n};
      sr_d  <= sr_s[1];
      b1_d  <= b1_s[1];
      b2_d  <= b2_s[1];
      b3_d  <= b3_s[1];
      tick_d <= timer_tick_interrupt;
    end
  end

  // level1/level3 trip on any change, level2 only on falling edge
  assign ev = {en82_q[7] & (b3_s[1] ^ b3_d),
               en82_q[6] & ~b2_s[1] & b2_d,
               en82_q[5] & (b1_s[1] ^ b1_d),
               en82_q[1] & sr_s[1] & ~sr_d,
               en82_q[0] & mode_change_event};
  assign ext_act = fen1_q[snc_pkg::B_EXT_EN] & (ext_s[1] ^ fen1_q[snc_pkg::B_EXT_POL]);

  // a read snapshots the flags; the ack write clears only what was seen
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_q  <= 5'h00;
      seen_q <= 5'h00;
    end else if (ce) begin
      if (rd && idx_q == snc_pkg::IDX_ACK)
        seen_q <= ack_q;
      ack_q <= (ack_q & ~((wr && idx_q == snc_pkg::IDX_ACK) ? seen_q : 5'h00)) | ev;
    end
  end

  // prescaler for the idle timers
  assign unit_tick = (unit_q == 32'(UNIT_CYC - 1));
  always_ff @(posedge mclk) begin
    if (rst)
      unit_q <= 32'h0000_0000;
    else if (ce)
      unit_q <= unit_tick ? 32'h0000_0000 : unit_q + 32'h0000_0001;
  end

  // device decode: 0 floppy, 1 hard drive, 2 pio
  logic [9:0] pio_mask;
  always_comb begin
    pio_mask = 10'(({3'h0, 1'b1} << piot_q[7:6]) - 4'h1);
    hit[0]   = (io_addr & ~snc_pkg::DRV_MASK) == snc_pkg::FDD_BASE;
    hit[1]   = (io_addr & ~snc_pkg::DRV_MASK) == snc_pkg::HDD_BASE;
    hit[2]   = (io_addr & ~pio_mask) == ({piob_q, 2'b00} & ~pio_mask);
    iact     = {1'b0, disk_irq, floppy_irq} & {3{irqa_q[0]}};
    tsel[0]  = drvt_q[3:0];
    tsel[1]  = drvt_q[7:4];
    tsel[2]  = piot_q[3:0];
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_dev
      logic arm_q, started_q;
      logic [3:0] cnt_q;
      // armed when the register bit reads 0
      assign trap[g]   = io_cycle_end & hit[g] & en41_q[g] & ~cpu_in_sysint
                         & (~started_q | ~arm_q);
      assign expire[g] = started_q & arm_q & (tsel[g] != 4'h0) & unit_tick
                         & (cnt_q >= tsel[g] - 4'h1);
      assign arm_w[g]  = arm_q;
      always_ff @(posedge mclk) begin
        if (rst) begin
          arm_q     <= snc_pkg::RST_ARM[g];
          started_q <= 1'b0;
          cnt_q     <= 4'h0;
        end else if (ce) begin
          if (wr && idx_q == snc_pkg::IDX_TRAP_ARM)
            arm_q <= hwdata[g];
          if (!en41_q[g])
            started_q <= 1'b0;
          if (trap[g]) begin
            arm_q     <= 1'b1;
            started_q <= 1'b1;
            cnt_q     <= 4'h0;
          end else if ((io_cycle_end & hit[g]) | iact[g]) begin
            cnt_q <= 4'h0;
          end else if (expire[g]) begin
            arm_q <= 1'b0;
          end else if (started_q && arm_q && unit_tick) begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (rst)
      pclr_q <= 3'h0;
    else if (ce)
      pclr_q <= expire;
  end

  assign misc_trap = io_cycle_end & ~cpu_in_sysint & (
                     (en41_q[snc_pkg::B_RTC_EN] & ((io_addr & ~10'h001) == snc_pkg::RTC_BASE)) |
                     (en41_q[snc_pkg::B_KBD_EN] & ((io_addr == snc_pkg::KBD_DATA) |
                                                   (io_addr == snc_pkg::KBD_CMD))));
  assign any_trap  = |trap | misc_trap;

  // source flags; hardware set wins over the clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_q   <= 7'h00;
      trapped_q <= 4'h0;
      rev_smi_q <= 1'b0;
    end else if (ce) begin
      flags_q <= (flags_q
                  & ~((rd && idx_q == snc_pkg::IDX_FLAGS) ? 7'h1f : 7'h00)
                  & ~((wr && idx_q == snc_pkg::IDX_PSTAT) ? 7'h60 : 7'h00))
                 | {en41_q[snc_pkg::B_TICK_EN] & timer_tick_interrupt & ~tick_d,
                    |ev[4:2] | ev[snc_pkg::S_MODE] | (wake_pend_q & in_high_speed),
                    misc_trap & io_addr[4],
                    misc_trap & ~io_addr[4],
                    trap[2], trap[0], trap[1]};
      if (any_trap)
        trapped_q <= {byte_high_enable_n, io_write_strobe_n,
                      io_read_strobe_n, io_addr[0]};
      if (core_reset_req)
        rev_smi_q <= cpu_in_sysint;
    end
  end
  // temporary-on sequencing
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      snc_pkg::ST_IDLE:
        if (ev[snc_pkg::S_WAKE])
          st_d = snc_pkg::ST_HSW;
        else if (|ev)
          st_d = snc_pkg::ST_ON;
      snc_pkg::ST_HSW:
        if (in_high_speed)
          st_d = snc_pkg::ST_ON;
      snc_pkg::ST_ON:
        if (wr && idx_q == snc_pkg::IDX_ACK)
          st_d = snc_pkg::ST_STOP;
      snc_pkg::ST_STOP:
        if (refresh_tick)
          st_d = snc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q        <= snc_pkg::ST_IDLE;
      wake_pend_q <= 1'b0;
      mode_src_q  <= 1'b0;
      act_lat_q   <= 1'b0;
      run_q       <= 1'b0;
      slow_q      <= 1'b0;
      hs_q        <= 1'b0;
      hold_q      <= 1'b0;
      adv_q       <= 1'b0;
      rep_q       <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      if (ev[snc_pkg::S_WAKE])
        wake_pend_q <= 1'b1;
      else if (in_high_speed)
        wake_pend_q <= 1'b0;
      hs_q <= wake_pend_q | ev[snc_pkg::S_WAKE];
      if (st_q == snc_pkg::ST_IDLE && |ev)
        mode_src_q <= ev[snc_pkg::S_MODE];
      // activity seen in ST_ON is replayed at exit
      if (st_q == snc_pkg::ST_ON && st_d != snc_pkg::ST_ON)
        act_lat_q <= 1'b0;
      else if (st_q == snc_pkg::ST_ON && (activity_event | wake_event))
        act_lat_q <= 1'b1;
      rep_q  <= (st_q == snc_pkg::ST_ON) && (st_d != snc_pkg::ST_ON)
                && (act_lat_q | activity_event | wake_event);
      adv_q  <= (st_q == snc_pkg::ST_ON) && (st_d == snc_pkg::ST_STOP) && mode_src_q;
      run_q  <= st_d != snc_pkg::ST_IDLE;
      slow_q <= (st_d != snc_pkg::ST_IDLE) && !in_pll_mode;
      hold_q <= (st_d == snc_pkg::ST_ON) || (st_d == snc_pkg::ST_HSW);
    end
  end

  // interrupt routing and handler-time controls
  always_ff @(posedge mclk) begin
    if (rst) begin
      smi_q <= 1'b0;
      nmi_q <= 1'b0;
      a20_q <= 1'b0;
      pg_q  <= 10'h000;
    end else if (ce) begin
      smi_q <= (|flags_q[4:0]) | flags_q[snc_pkg::B_TICK_FLAG] | ext_act
               | (flags_q[snc_pkg::B_PMU_FLAG] & sock_q[snc_pkg::B_SMI_SEL]);
      nmi_q <= flags_q[snc_pkg::B_PMU_FLAG] & ~sock_q[snc_pkg::B_SMI_SEL];
      a20_q <= a20c_q[0] & cpu_in_sysint;
      pg_q  <= {sock_q[5:4], page_q};
    end
  end

  assign hreadyout          = rdy_q;
  assign hrdata             = rdat_q;
  assign hresp              = 1'b0;
  assign sysint_req         = smi_q;
  assign nmi_req            = nmi_q;
  assign clk_run            = run_q;
  assign slow_clk_sel       = slow_q;
  assign goto_high_speed    = hs_q;
  assign hold_power_unit    = hold_q;
  assign advance_mode       = adv_q;
  assign replay_activity    = rep_q;
  assign a20_force_low      = a20_q;
  assign save_page          = pg_q;
  assign device_power_clear = pclr_q;
  assign force_mode_valid   = fv_q;
  assign force_mode         = fm_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_nmi_cause;
    nmi_q |-> $past(flags_q[snc_pkg::B_PMU_FLAG]) && !$past(sock_q[snc_pkg::B_SMI_SEL]);
  endproperty
  a_nmi_cause: assert property (p_nmi_cause) else $error("nmi without routable source");
  property p_route;
    ce && flags_q[snc_pkg::B_PMU_FLAG] && !sock_q[snc_pkg::B_SMI_SEL] |=> nmi_q;
  endproperty
  a_route: assert property (p_route) else $error("routable source not sent to nmi");
  property p_hs_first;
    ce && wake_pend_q && !in_high_speed |=> hs_q && !(st_q == snc_pkg::ST_ON);
  endproperty
  a_hs_first: assert property (p_hs_first) else $error("wake raised before high speed");
  property p_adv;
    ce && st_q == snc_pkg::ST_ON && st_d == snc_pkg::ST_STOP && mode_src_q |=> adv_q ##1 (!adv_q || !ce);
  endproperty
  a_adv: assert property (p_adv) else $error("mode advance pulse wrong");
  property p_stop;
    ce && st_q == snc_pkg::ST_STOP && refresh_tick |=> !run_q && st_q == snc_pkg::ST_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("clocks not stopped at refresh");
  property p_hold;
    st_q == snc_pkg::ST_ON |-> hold_q && run_q;
  endproperty
  a_hold: assert property (p_hold) else $error("temporary-on not holding");
  property p_a20;
    ce && cpu_in_sysint && a20c_q[0] |=> a20_q;
  endproperty
  a_a20: assert property (p_a20) else $error("a20 not forced");
  property p_notrap;
    cpu_in_sysint |-> trap == 3'h0 && !misc_trap;
  endproperty
  a_notrap: assert property (p_notrap) else $error("trap during handler");
  property p_pwr;
    ce && |expire |=> pclr_q == $past(expire) ##1 (pclr_q == 3'h0 || !ce || $past(|expire));
  endproperty
  a_pwr: assert property (p_pwr) else $error("power bit not cleared on expiry");
  property p_page;
    ce |=> pg_q == $past({sock_q[5:4], page_q});
  endproperty
  a_page: assert property (p_page) else $error("save page wrong");

  c_trap: cover property (ce && |trap);
  c_exit: cover property (st_q == snc_pkg::ST_STOP ##1 st_q == snc_pkg::ST_IDLE);
  c_nmi:  cover property ($rose(nmi_q));
endmodule
`default_nettype wire

/* snc_core_model.sv */
// core model: handler state and refresh pulses
`timescale 1ns/1ps
`default_nettype none
module snc_core_model #(
  parameter int REF_CYC = 16
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // requests and core state
  input  wire logic sysint_req,
  output logic      cpu_in_sysint,
  output logic      refresh_tick
);
  int cnt_q;
  // refresh runs always, so a forced-on clock always meets a stop point
  always_ff @(posedge mclk) begin
    cnt_q <= (rst || cnt_q == REF_CYC - 1) ? 0 : cnt_q + 1;
    refresh_tick <= !rst && cnt_q == REF_CYC - 1;
  end
  // handler runs while the request stands; ack is written last by the bench
  always_ff @(posedge mclk) begin
    cpu_in_sysint <= !rst && sysint_req;
  end
endmodule
`default_nettype wire

/* tb_top.sv */
// testbench: register, trap, routing and save page checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk = 0, rst = 1, hwrite = 0, hreadyout, hresp, sysint_req, nmi_req, clk_run;
  logic        cpu_in_sysint, refresh_tick, io_cycle_end = 0, mode_change_event = 0;
  logic        external_sysint_pin = 0, suspend_resume_pin = 0, in_pll_mode = 0, in_high_speed = 0;
  logic        battery_level_one_n = 1, battery_level_two_n = 1, battery_level_three_n = 1;
  logic        activity_event = 0, wake_event = 0, core_reset_req = 0, timer_tick_interrupt = 0;
  logic        floppy_irq = 0, disk_irq = 0, io_read_strobe_n = 1, io_write_strobe_n = 1;
  logic        byte_high_enable_n = 1;
  logic        hold_power_unit, slow_clk_sel, a20_force_low, advance_mode, replay_activity, force_mode_valid;
  logic [2:0]  force_mode, device_power_clear, pwr_off = 0;
  logic [2:0]  power_mode = 0;
  logic [1:0]  htrans = 0;
  logic [9:0]  io_addr = 0, save_page;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  int          mismatches, checks;

  snc_ctl #(.UNIT_CYC(4)) u_snc_ctl (
    .mclk, .rst, .ce(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .external_sysint_pin, .suspend_resume_pin,
    .battery_level_one_n, .battery_level_two_n, .battery_level_three_n, .mode_change_event,
    .power_mode, .in_pll_mode, .in_high_speed, .activity_event, .wake_event, .refresh_tick,
    .cpu_in_sysint, .core_reset_req, .timer_tick_interrupt, .floppy_irq, .disk_irq, .io_cycle_end,
    .io_addr, .io_read_strobe_n, .io_write_strobe_n, .byte_high_enable_n, .sysint_req, .nmi_req,
    .clk_run, .slow_clk_sel, .goto_high_speed(), .hold_power_unit, .advance_mode,
    .replay_activity, .a20_force_low, .save_page, .device_power_clear, .force_mode_valid,
    .force_mode);
  snc_core_model u_snc_core_model (.mclk, .rst, .sysint_req, .cpu_in_sysint, .refresh_tick);

  // expiry pulses last one cycle, so remember them
  always @(posedge mclk) begin
    if (!rst)
      pwr_off <= pwr_off | device_power_clear;
  end

  initial forever #25 mclk = ~mclk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one word transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic t_regs();
    bus(0, snc_pkg::IDX_REV, 0);
    chk("rev", {28'h0, snc_pkg::REV_CODE}, rd);
    bus(0, 8'hff, 0);
    chk("unmapped", 32'h0000_0000, {rd[31:1], hresp});
    $display("test regs done");
  endtask

  task automatic t_trap();
    bus(1, snc_pkg::IDX_A20, 8'h01);
    bus(1, snc_pkg::IDX_SRC_EN, 8'h01);
    io_addr <= snc_pkg::FDD_BASE;
    io_read_strobe_n <= 0;
    io_cycle_end <= 1;
    @(posedge mclk);
    io_cycle_end <= 0;
    repeat (2) @(posedge mclk);
    chk("trap req", 1, sysint_req);
    core_reset_req <= 1;
    @(posedge mclk);
    core_reset_req <= 0;
    bus(0, snc_pkg::IDX_FLAGS, 0);
    chk("floppy flag", 1, rd[1]);
    chk("a20", 1, a20_force_low);
    bus(0, snc_pkg::IDX_REV, 0);
    chk("rev smi", {24'h00_0000, 4'h8, snc_pkg::REV_CODE}, rd);
    bus(0, snc_pkg::IDX_TRAPPED, 0);
    chk("trapped", 32'h0000_000c, rd);
    bus(1, snc_pkg::IDX_DRV_TMR, 8'h01);
    repeat (12) @(posedge mclk);
    bus(0, snc_pkg::IDX_TRAP_ARM, 0);
    chk("arm", 32'h0000_0006, rd);
    chk("power off", 3'b001, pwr_off);
    $display("test trap done");
  endtask

  task automatic pulse_mode();
    mode_change_event <= 1;
    @(posedge mclk);
    mode_change_event <= 0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic t_route();
    bus(1, snc_pkg::IDX_PWR_EN, 8'h01);
    pulse_mode();
    chk("nmi", 2'b10, {nmi_req, sysint_req});
    chk("clk on", 1, clk_run);
    chk("hold slow", 2'b11, {hold_power_unit, slow_clk_sel});
    activity_event <= 1;
    @(posedge mclk);
    activity_event <= 0;
    bus(0, snc_pkg::IDX_FLAGS, 0);
    chk("power flag", 1, rd[5]);
    bus(0, snc_pkg::IDX_ACK, 0);
    chk("ack src", 1, rd);
    bus(1, snc_pkg::IDX_PSTAT, 0);
    bus(0, snc_pkg::IDX_ACK, 0);
    bus(1, snc_pkg::IDX_ACK, 0);
    chk("exit", 2'b11, {advance_mode, replay_activity});
    repeat (20) @(posedge mclk);
    chk("clk stop", 0, clk_run);
    bus(1, snc_pkg::IDX_SOCKET, 8'h80);
    pulse_mode();
    chk("smi", 2'b01, {nmi_req, sysint_req});
    $display("test route done");
  endtask

  task automatic t_page();
    bus(1, snc_pkg::IDX_PAGE, 8'h5a);
    bus(1, snc_pkg::IDX_SOCKET, 8'h30);
    @(posedge mclk);
    chk("page", 10'h35a, save_page);
    bus(1, snc_pkg::IDX_FORCE, 8'h05);
    chk("force", 4'hd, {force_mode_valid, force_mode});
    $display("test page done");
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    t_regs();
    t_trap();
    t_route();
    t_page();
    close_out();
  end

  // tests need well under 2000 cycles
  initial begin
    #100us;
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
